// ### art_defs.svh
/*
  Offsets, field positions, reset values and sizes for the auto-reload PWM timer.
  Assumes inclusion by bare name from the timer package and module.
*/
`ifndef ART_DEFS_SVH
`define ART_DEFS_SVH

`define ART_OFS_CSR        4'h0
`define ART_OFS_CNT        4'h1
`define ART_OFS_RELOAD     4'h2
`define ART_OFS_PWMCTL     4'h3
`define ART_OFS_DUTY0      4'h4
`define ART_CSR_EXTSEL     7
`define ART_CSR_PSC_HI     6
`define ART_CSR_PSC_LO     4
`define ART_CSR_RUN        3
`define ART_CSR_FORCE      2
`define ART_CSR_OIE        1
`define ART_CSR_OVF        0
`define ART_RESET_BYTE     8'h00
`define ART_CHANNELS       4
`define ART_PSC_BITS       7
`define ART_UNMAPPED_DATA  32'h0000_0000

`endif

// ### art_pkg.sv
/*
  Types shared by the auto-reload PWM timer.
  Assumes art_defs.svh is on the include path.
*/
`include "art_defs.svh"
package art_pkg;
  typedef struct packed {
    logic       ext_sel;
    logic [2:0] prescale_select;
    logic       run;
    logic       overflow_irq_enable;
  } ctl_t;

  typedef struct packed {
    logic [3:0] channel_output_enable;
    logic [3:0] channel_polarity;
  } pwmctl_t;
endpackage : art_pkg

// ### art_timer.sv
/*
  Auto-reload 8-bit timer with prescaler, four double-buffered PWM channels,
  overflow flag and interrupt, and external event counting.
  Assumes an Avalon-MM master on CLOCK_IN, word addressing, and an event pin
  asynchronous to CLOCK_IN that is slower than a quarter of the clock rate.
*/
`timescale 1ns/1ps
`include "art_defs.svh"
module art_timer (
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        CLK_EN_IN,
  input  wire logic        HALT_IN,
  input  wire logic        EVENT_IN,
  input  wire logic [3:0]  AVS_ADDRESS_IN,
  input  wire logic        AVS_READ_IN,
  input  wire logic        AVS_WRITE_IN,
  input  wire logic [31:0] AVS_WRITEDATA_IN,
  input  wire logic [3:0]  AVS_BYTEENABLE_IN,
  output logic      [31:0] AVS_READDATA_OUT,
  output logic             AVS_WAITREQUEST_OUT,
  output logic             IRQ_OUT,
  output logic             WAKEUP_OUT,
  output logic      [3:0]  PWM_OUT,
  output logic      [3:0]  PWM_OE_OUT
);

  localparam int NCH = `ART_CHANNELS;

  // Register-bus state.
  art_pkg::ctl_t    ctl_r, ctl_nxt;
  art_pkg::pwmctl_t pwmctl_r, pwmctl_nxt;
  logic [7:0]  reload_r, reload_nxt;
  logic [7:0]  duty_r [NCH];
  logic [7:0]  duty_nxt [NCH];
  logic        ovf_r, ovf_nxt;
  logic        ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  // Counting state.
  logic [7:0]  count_r, count_nxt;
  logic [6:0]  psc_r, psc_nxt;
  logic [7:0]  shadow_compare_r [NCH];
  logic [7:0]  shadow_compare_nxt [NCH];
  logic [3:0]  active_r, active_nxt;
  // Event synchroniser.
  logic        ev_s1_r, ev_s2_r, ev_s3_r;

  logic        bus_req, wr_go, rd_go, lane0;
  logic        wr_csr, wr_cnt, force_go, input_tick, cnt_tick, ovf_evt, regs_frozen;

  function automatic logic [7:0] read_mux(input logic [3:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      `ART_OFS_CSR:    v = {ctl_r.ext_sel, ctl_r.prescale_select, ctl_r.run,
                            1'b0, ctl_r.overflow_irq_enable, ovf_r};
      `ART_OFS_CNT:    v = count_r;
      `ART_OFS_RELOAD: v = reload_r;
      `ART_OFS_PWMCTL: v = pwmctl_r;
      `ART_OFS_DUTY0, 4'h5, 4'h6, 4'h7: v = duty_r[a[1:0]];
      default:         v = 8'h00;
    endcase
    return v;
  endfunction : read_mux

  function automatic logic mapped(input logic [3:0] a);
    return a <= 4'h7;
  endfunction : mapped

  // One-cycle wait on every access; the answer comes on the second edge.
  assign bus_req             = (AVS_READ_IN | AVS_WRITE_IN) & ~ack_r;
  assign AVS_WAITREQUEST_OUT = (AVS_READ_IN | AVS_WRITE_IN) & ~ack_r;
  assign AVS_READDATA_OUT    = rdata_r;
  // In HALT, whichever clock is chosen, bus writes to the registers are ignored.
  assign regs_frozen = HALT_IN;
  assign lane0  = AVS_BYTEENABLE_IN[0];
  assign wr_go  = AVS_WRITE_IN & ack_r & lane0 & ~regs_frozen;
  // Read data are captured on the first edge so they stand at the acking edge.
  assign rd_go  = AVS_READ_IN & ~ack_r;
  assign wr_csr = wr_go & (AVS_ADDRESS_IN == `ART_OFS_CSR);
  assign wr_cnt = wr_go & (AVS_ADDRESS_IN == `ART_OFS_CNT);
  assign force_go = wr_csr & AVS_WRITEDATA_IN[`ART_CSR_FORCE];

  always_comb begin
    ctl_nxt    = ctl_r;
    pwmctl_nxt = pwmctl_r;
    reload_nxt = reload_r;
    ack_nxt    = bus_req;
    rdata_nxt  = rdata_r;
    for (int i = 0; i < NCH; i++) begin
      duty_nxt[i] = duty_r[i];
    end
    if (rd_go) begin
      rdata_nxt = mapped(AVS_ADDRESS_IN) ? {24'h000000, read_mux(AVS_ADDRESS_IN)}
                                         : `ART_UNMAPPED_DATA;
    end
    if (wr_csr) begin
      ctl_nxt.ext_sel         = AVS_WRITEDATA_IN[`ART_CSR_EXTSEL];
      ctl_nxt.prescale_select = AVS_WRITEDATA_IN[`ART_CSR_PSC_HI:`ART_CSR_PSC_LO];
      ctl_nxt.run             = AVS_WRITEDATA_IN[`ART_CSR_RUN];
      ctl_nxt.overflow_irq_enable             = AVS_WRITEDATA_IN[`ART_CSR_OIE];
    end
    if (wr_go && AVS_ADDRESS_IN == `ART_OFS_RELOAD) begin
      reload_nxt = AVS_WRITEDATA_IN[7:0];
    end
    if (wr_go && AVS_ADDRESS_IN == `ART_OFS_PWMCTL) begin
      pwmctl_nxt = AVS_WRITEDATA_IN[7:0];
    end
    if (wr_go && AVS_ADDRESS_IN[3:2] == 2'b01) begin
      duty_nxt[AVS_ADDRESS_IN[1:0]] = AVS_WRITEDATA_IN[7:0];
    end
  end

  // Overflow flag: a new overflow wins over the clearing read.
  always_comb begin
    ovf_nxt = ovf_r;
    if (rd_go && AVS_ADDRESS_IN == `ART_OFS_CSR) begin
      ovf_nxt = 1'b0;
    end
    if (ovf_evt) begin
      ovf_nxt = 1'b1;
    end
  end

  assign IRQ_OUT    = ovf_r & ctl_r.overflow_irq_enable;
  assign WAKEUP_OUT = IRQ_OUT & HALT_IN;

  // Counter input: CPU clock, or one tick per synchronised rising event edge.
  assign input_tick = ctl_r.ext_sel ? (ev_s2_r & ~ev_s3_r) : ~HALT_IN;

  always_comb begin
    logic [7:0] mask;
    mask     = 8'h00;
    psc_nxt  = psc_r;
    cnt_tick = 1'b0;
    mask     = 8'((9'h001 << ctl_r.prescale_select) - 9'h001);
    if (ctl_r.run && input_tick) begin
      psc_nxt  = psc_r + 7'h01;
      cnt_tick = ({1'b0, psc_r} & mask) == mask;
    end
    if (force_go || wr_cnt) begin
      psc_nxt = 7'h00;
    end
  end

  assign ovf_evt = cnt_tick & (count_r == 8'hff) & ~force_go & ~wr_cnt;

  always_comb begin
    count_nxt  = count_r;
    active_nxt = active_r;
    for (int i = 0; i < NCH; i++) begin
      shadow_compare_nxt[i] = shadow_compare_r[i];
    end
    if (force_go) begin
      count_nxt = reload_r;
    end else if (wr_cnt) begin
      count_nxt = AVS_WRITEDATA_IN[7:0];
    end else if (ovf_evt) begin
      count_nxt  = reload_r;
      active_nxt = 4'hf;
      for (int i = 0; i < NCH; i++) begin
        shadow_compare_nxt[i] = duty_r[i];
      end
    end else if (cnt_tick) begin
      count_nxt = count_r + 8'h01;
    end
    // Compare on the next count so both edges of the pulse line up with the count.
    for (int i = 0; i < NCH; i++) begin
      if (!ovf_evt && count_nxt > shadow_compare_nxt[i]) begin
        active_nxt[i] = 1'b0;
      end
    end
  end

  // Polarity is applied before the register, from the next-state value, so a change shows on the writing edge.
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_pin
      always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
          PWM_OUT[g]    <= 1'b0;
          PWM_OE_OUT[g] <= 1'b0;
        end else if (CLK_EN_IN && !HALT_IN) begin
          PWM_OUT[g]    <= active_nxt[g] ^ pwmctl_nxt.channel_polarity[g];
          PWM_OE_OUT[g] <= pwmctl_nxt.channel_output_enable[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ctl_r    <= '0;
      pwmctl_r <= `ART_RESET_BYTE;
      reload_r <= `ART_RESET_BYTE;
      ovf_r    <= 1'b0;
      ack_r    <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      count_r  <= `ART_RESET_BYTE;
      psc_r    <= 7'h00;
      active_r <= 4'h0;
      ev_s1_r  <= 1'b0;
      ev_s2_r  <= 1'b0;
      ev_s3_r  <= 1'b0;
      for (int i = 0; i < NCH; i++) begin
        duty_r[i]           <= `ART_RESET_BYTE;
        shadow_compare_r[i] <= `ART_RESET_BYTE;
      end
    end else if (CLK_EN_IN) begin
      ctl_r    <= ctl_nxt;
      pwmctl_r <= pwmctl_nxt;
      reload_r <= reload_nxt;
      ovf_r    <= ovf_nxt;
      ack_r    <= ack_nxt;
      rdata_r  <= rdata_nxt;
      count_r  <= count_nxt;
      psc_r    <= psc_nxt;
      active_r <= active_nxt;
      ev_s1_r  <= EVENT_IN;
      ev_s2_r  <= ev_s1_r;
      ev_s3_r  <= ev_s2_r;
      for (int i = 0; i < NCH; i++) begin
        duty_r[i]           <= duty_nxt[i];
        shadow_compare_r[i] <= shadow_compare_nxt[i];
      end
    end
  end

endmodule : art_timer

// ### art_timer_checker.sv
/*
  Port checker for the auto-reload PWM timer.
  Assumes the bind at the foot of this file and a tied-high clock enable.
*/
`timescale 1ns/1ps
module art_timer_checker (
  input wire logic        CLOCK_IN,
  input wire logic        RST_N_IN,
  input wire logic        HALT_IN,
  input wire logic [3:0]  AVS_ADDRESS_IN,
  input wire logic        AVS_READ_IN,
  input wire logic        AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [31:0] AVS_READDATA_OUT,
  input wire logic        AVS_WAITREQUEST_OUT,
  input wire logic        IRQ_OUT,
  input wire logic        WAKEUP_OUT,
  input wire logic [3:0]  PWM_OUT,
  input wire logic [3:0]  PWM_OE_OUT
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);
  logic       csr_hit_r;
  logic       csr_hit_nxt;
  logic [3:0] oe_req;
  assign oe_req = AVS_WRITEDATA_IN[7:4];
  sequence csr_rd_s;
    AVS_READ_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == 4'h0;
  endsequence
  always_comb csr_hit_nxt = (AVS_READ_IN || AVS_WRITE_IN) && AVS_ADDRESS_IN == 4'h0;
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) csr_hit_r <= 1'b0;
    else csr_hit_r <= csr_hit_nxt;
  end
  reset_clear_a: assert property (!$past(RST_N_IN) |-> PWM_OUT == 4'h0 && !IRQ_OUT)
    else $error("outputs not clear after reset");
  enable_write_a: assert property (AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && !HALT_IN
    && AVS_ADDRESS_IN == 4'h3 |=> PWM_OE_OUT == $past(oe_req)) else $error("enables not loaded");
  halt_freeze_a: assert property (HALT_IN && $past(HALT_IN) && $past(HALT_IN, 2)
    |-> $stable(PWM_OUT)) else $error("pwm moved in halt");
  flag_clear_a: assert property ($fell(IRQ_OUT) |-> csr_hit_r)
    else $error("flag cleared without status access");
  wake_level_a: assert property (WAKEUP_OUT == (IRQ_OUT && HALT_IN))
    else $error("wakeup level wrong");
  force_zero_a: assert property (csr_rd_s |=> !AVS_READDATA_OUT[2])
    else $error("force bit read as one");
  one_wait_a: assert property ((AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT
    |=> !AVS_WAITREQUEST_OUT) else $error("access not answered");
  byte_wide_a: assert property (AVS_READDATA_OUT[31:8] == 24'h0)
    else $error("upper read bits set");
endmodule : art_timer_checker

bind art_timer art_timer_checker art_timer_checker_inst (.*);

// ### art_load_model.sv
/*
  Loads on the PWM pins and the external event source.
  Assumes the bench calls send_events right after a rising clock edge.
*/
`timescale 1ns/1ps
module art_load_model (
  input  wire logic       clk_in,
  input  wire logic [3:0] pwm_in,
  input  wire logic [3:0] oe_in,
  output logic      [3:0] pin_out,
  output logic            event_out
);
  // Released pins fall to their pull-down.
  assign pin_out = pwm_in & oe_in;
  initial event_out = 1'b0;
  task automatic send_events(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk_in);
      event_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      event_out <= 1'b0;
    end
  endtask : send_events
endmodule : art_load_model

// ### tb_top.sv
/*
  Self-checking bench for the PWM timer, one task per test.
  Assumes art_timer, its bound checker and art_load_model.
*/
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0, rst_n = 1'b0, halt = 1'b0, rd = 1'b0, wr = 1'b0;
  logic [3:0]  adr = 4'h0, pwm, oe, pin;
  logic [31:0] wd = 32'h0, rdat;
  logic        wt, irq, wake, evt;
  int          n_mismatch = 0, samples_checked = 0;
  always #25 clk = ~clk;
  art_timer art_timer_inst (.CLOCK_IN(clk), .RST_N_IN(rst_n), .CLK_EN_IN(1'b1),
    .HALT_IN(halt), .EVENT_IN(evt), .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd),
    .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(4'hf),
    .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wt), .IRQ_OUT(irq),
    .WAKEUP_OUT(wake), .PWM_OUT(pwm), .PWM_OE_OUT(oe));
  art_load_model art_load_model_inst (.clk_in(clk), .pwm_in(pwm), .oe_in(oe),
    .pin_out(pin), .event_out(evt));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // A read compares the byte standing at the acking edge with d.
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= {24'h0, d};
    do @(posedge clk); while (wt !== 1'b0);
    if (!w) chk({8'h0, rdat[7:0]}, {8'h0, d});
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask : bus
  // Skips to a clean rise, then measures one high and one low phase.
  task automatic pulse(input int c, input logic [15:0] hi, input logic [15:0] lo);
    logic [15:0] n[4];
    for (int k = 0; k < 4; k++) begin
      n[k] = 16'h0;
      do begin
        @(negedge clk);
        n[k]++;
      end while (pin[c] !== k[0] && n[k] < 16'd9000);
    end
    chk(n[2], hi);
    chk(n[3], lo);
    @(posedge clk);
  endtask : pulse
  task automatic t_regs;
    for (int a = 0; a < 8; a++) bus(1'b0, a[3:0], 8'h00);
    for (int a = 1; a < 8; a++) bus(1'b1, a[3:0], 8'h90 + a[7:0]);
    for (int a = 1; a < 8; a++) bus(1'b0, a[3:0], 8'h90 + a[7:0]);
    chk({12'h0, oe}, 16'h0009);
    bus(1'b1, 4'h9, 8'hff);
    bus(1'b0, 4'h9, 8'h00);
    bus(1'b1, 4'h0, 8'h04);
    bus(1'b0, 4'h0, 8'h00);
    bus(1'b0, 4'h1, 8'h92);
    $display("regs test done");
  endtask : t_regs
  task automatic t_pwm;
    bus(1'b1, 4'h2, 8'hf0);
    bus(1'b1, 4'h4, 8'hf8);
    bus(1'b1, 4'h5, 8'hf8);
    bus(1'b1, 4'h3, 8'h32);
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, 4'h0, {1'b0, c[2:0], 4'hc});
      pulse(0, 16'd9 << c, 16'd7 << c);
    end
    bus(1'b1, 4'h0, 8'h0c);
    bus(1'b1, 4'h4, 8'hfc);
    pulse(0, 16'd13, 16'd3);
    @(negedge clk);
    chk({15'h0, pin[1]}, {15'h0, ~pin[0]});
    @(posedge clk);
    bus(1'b1, 4'h3, 8'h33);
    @(negedge clk);
    chk({15'h0, pin[0]}, 16'h0);
    @(posedge clk);
    $display("pwm test done");
  endtask : t_pwm
  task automatic t_flag;
    bus(1'b1, 4'h0, 8'h00);
    bus(1'b0, 4'h0, 8'h01);
    bus(1'b1, 4'h0, 8'h0e);
    for (int t = 0; t < 40 && irq !== 1'b1; t++) @(negedge clk);
    chk({15'h0, irq}, 16'h0001);
    @(posedge clk);
    bus(1'b0, 4'h0, 8'h0b);
    bus(1'b0, 4'h0, 8'h0a);
    $display("flag test done");
  endtask : t_flag
  task automatic t_count;
    bus(1'b1, 4'h0, 8'h00);
    bus(1'b1, 4'h1, 8'h40);
    repeat (5) @(posedge clk);
    bus(1'b0, 4'h1, 8'h40);
    bus(1'b1, 4'h0, 8'h78);
    repeat (125) @(posedge clk);
    bus(1'b1, 4'h1, 8'h40);
    bus(1'b0, 4'h1, 8'h40);
    repeat (130) @(posedge clk);
    bus(1'b0, 4'h1, 8'h41);
    $display("count test done");
  endtask : t_count
  task automatic t_event;
    bus(1'b1, 4'h2, 8'hfd);
    bus(1'b1, 4'h0, 8'h8e);
    halt <= 1'b1;
    bus(1'b1, 4'h2, 8'h00);
    art_load_model_inst.send_events(2);
    repeat (6) @(negedge clk);
    chk({15'h0, irq}, 16'h0);
    @(posedge clk);
    art_load_model_inst.send_events(1);
    repeat (6) @(negedge clk);
    chk({14'h0, irq, wake}, 16'h0003);
    @(posedge clk);
    halt <= 1'b0;
    bus(1'b0, 4'h2, 8'hfd);
    bus(1'b0, 4'h0, 8'h8b);
    $display("event test done");
  endtask : t_event
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  initial begin
    #(40000 * 50);
    n_mismatch++;
    final_report;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs;
    t_pwm;
    t_flag;
    t_count;
    t_event;
    final_report;
  end
endmodule : tb_top
